// [hdl/mtw_timer_regs.vh]
// Register map, field positions, reset values and timing counts of the timer
`ifndef MTW_TIMER_REGS_VH
`define MTW_TIMER_REGS_VH

// Register addresses (11-bit address space)
`define MTW_ADDR_W 11
`define MTW_ADDR_STATUS 11'h008
`define MTW_ADDR_COUNT 11'h009
`define MTW_ADDR_WDOG_CLR 11'h7F0

// Status/control field positions
`define MTW_BIT_OVF_FLAG 7
`define MTW_BIT_PER_FLAG 6
`define MTW_BIT_OVF_IE 5
`define MTW_BIT_PER_IE 4
`define MTW_BIT_OVF_FRST 3
`define MTW_BIT_PER_FRST 2
`define MTW_BIT_RATE_HI 1
`define MTW_BIT_RATE_LO 0
`define MTW_BIT_WDOG_CLR 0

// Reset values
`define MTW_RATE_RST 2'h3
`define MTW_ZERO8 8'h00

// Chain shape: prescale, stage count, tap base, watchdog depth
`define MTW_PRESCALE_W 2
`define MTW_STAGES 15
`define MTW_TAP_BASE 11
`define MTW_WDOG_W 3
`define MTW_WDOG_TIMEOUT 3'h7

// Power-on delays in operating clock cycles
`define MTW_POR_LONG 4064
`define MTW_POR_SHORT 16

`endif

// [hdl/mtw_watchdog.v]
// Watchdog counter clocked by the selected periodic tap
`timescale 1ns/1ps
module mtw_watchdog #(
  parameter WIDTH = 3
) (
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Control
  input wire tick,
  input wire clear,
  input wire enable,
  // Result
  output reg expired
);
`include "mtw_timer_regs.vh"

  reg [WIDTH-1:0] countFf;

  // Counts tap periods; clear has priority so a kick never loses to a tick
  always @(posedge sys_clk) begin
    if (!rstn || clear || !enable) begin
      countFf <= {WIDTH{1'b0}};
      expired <= 1'b0;
    end else if (tick) begin
      countFf <= countFf + {{(WIDTH-1){1'b0}}, 1'b1};
      expired <= (countFf == `MTW_WDOG_TIMEOUT - 3'h1); // [RULE12] [RULE17]
    end else begin
      expired <= 1'b0;
    end
  end
endmodule

// [hdl/mtw_timer.v]
// Multifunction timer with periodic tap, overflow flag and watchdog
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
// Overview of operation
// [RULE1] Overflow flag sets when low eight stages wrap from FF to 00.
// [RULE2] Overflow interrupt request while overflow flag and its enable are set.
// [RULE3] Writing one to overflow flag reset clears it; flag writes ignored.
// [RULE4] Periodic flag sets on selected tap; interrupt when flag and enable set.
// [RULE5] Writing one to periodic flag reset clears the periodic flag.
// [RULE6] Both flags read-only and cleared by reset.
// [RULE7] Flag reset bits are write-only, read zero, cleared by reset.
// [RULE8] Both interrupt enables read/write; one enables, zero disables.
// [RULE9] Rate select codes 00..11 pick clock divided by 2^14..2^17.
// [RULE10] Reset sets both rate select bits, slowest rate.
// [RULE11] Watchdog is clocked from the selected periodic tap.
// [RULE12] Watchdog times out after seven tap periods, minus zero plus one; code expires on the seventh tap after a clear, six to seven periods.
// [RULE13] Software should clear watchdog just before changing rate select.
// [RULE14] Fifteen-stage counter; low eight stages readable in count register.
// [RULE15] Power-on clears chain, waits 4064 or 16 cycles, clears again.
// [RULE16] Eighth-stage overflow occurs every 1024 clock cycles.
// [RULE17] Watchdog expiry without clear requests a chip reset.
// [RULE18] Writing zero to bit 0 of watchdog clear register clears watchdog.
// [RULE19] Watchdog clear bit is write-only; reads return undefined data.
// [RULE20] Stop instruction switches the watchdog off.
// [RULE21] Option bit enables watchdog when one; disabled never resets.
// [RULE22] Divide-by-four prescale feeds first counter stage.
module mtw_timer #(
  parameter POR_LONG = `MTW_POR_LONG,
  parameter POR_SHORT = `MTW_POR_SHORT
) (
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Register port
  input wire [10:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [7:0] regRdata,
  // Option byte and core state
  input wire watchdogEnableOption,
  input wire shortStartupDelayOption,
  input wire stopMode,
  // Requests
  output reg overflowIrq,
  output reg periodicIrq,
  output reg watchdogResetReq,
  output reg porActive
);
`include "mtw_timer_regs.vh"

  localparam ST_POR = 1'b0;
  localparam ST_RUN = 1'b1;

  reg stateFf;
  reg [12:0] porCntFf;
  reg [`MTW_PRESCALE_W-1:0] preFf;
  reg [`MTW_STAGES-1:0] chainFf;
  reg overflowFlagFf;
  reg periodicFlagFf;
  reg overflowIrqEnableFf;
  reg periodicIrqEnableFf;
  reg [1:0] rateSelFf;
  reg tapPrevFf;
  reg [`MTW_STAGES:0] chainWide;
  reg [3:0] tapVec;
  wire preWrap;
  wire lowWrap;
  wire tapLevel;
  wire periodicTap;
  wire wrStatus;
  wire wdClear;
  wire wdExpired;
  wire [12:0] porLimit;

  assign wrStatus = regWr && (regAddr == `MTW_ADDR_STATUS);
  assign preWrap = (preFf == {`MTW_PRESCALE_W{1'b1}}); // [RULE22]
  assign lowWrap = preWrap && (chainFf[7:0] == 8'hFF); // [RULE1] [RULE16]
  assign porLimit = shortStartupDelayOption ? POR_SHORT[12:0] : POR_LONG[12:0];

  // Tap outputs per rate code: stage feeding 2^14..2^17 division
  always @* begin
    chainWide = {1'b0, chainFf};
    tapVec = chainWide[`MTW_TAP_BASE +: 4];
  end
  assign tapLevel = tapVec[rateSelFf]; // [RULE9]
  // Falling edge of the tap stage marks one full period
  assign periodicTap = tapPrevFf && !tapLevel && (stateFf == ST_RUN); // [RULE4]
  assign wdClear = regWr && (regAddr == `MTW_ADDR_WDOG_CLR)
    && !regWdata[`MTW_BIT_WDOG_CLR]; // [RULE18]

  // Power-on sequencer; chain runs during the delay, then restarts
  always @(posedge sys_clk) begin
    if (!rstn) begin
      stateFf <= ST_POR;
      porCntFf <= 13'h0000;
      porActive <= 1'b1;
    end else begin
      case (stateFf)
        ST_POR: begin
          porCntFf <= porCntFf + 13'h0001;
          if (porCntFf == porLimit - 13'h0001) begin
            stateFf <= ST_RUN; // [RULE15]
            porActive <= 1'b0;
          end
        end
        ST_RUN: porActive <= 1'b0;
        default: stateFf <= ST_POR;
      endcase
    end
  end

  // Prescaler and fifteen-stage chain, cleared at release of power-on
  always @(posedge sys_clk) begin
    if (!rstn || (stateFf == ST_POR && porCntFf == porLimit - 13'h0001)) begin
      preFf <= {`MTW_PRESCALE_W{1'b0}}; // [RULE15]
      chainFf <= {`MTW_STAGES{1'b0}};
      tapPrevFf <= 1'b0;
    end else begin
      preFf <= preFf + {{(`MTW_PRESCALE_W-1){1'b0}}, 1'b1}; // [RULE22]
      if (preWrap)
        chainFf <= chainFf + {{(`MTW_STAGES-1){1'b0}}, 1'b1}; // [RULE14]
      tapPrevFf <= tapLevel;
    end
  end

  // Control bits; flags set by hardware win over a same-cycle clear
  always @(posedge sys_clk) begin
    if (!rstn) begin
      overflowFlagFf <= 1'b0; // [RULE6]
      periodicFlagFf <= 1'b0;
      overflowIrqEnableFf <= 1'b0;
      periodicIrqEnableFf <= 1'b0;
      rateSelFf <= `MTW_RATE_RST; // [RULE10]
    end else begin
      if (wrStatus) begin
        overflowIrqEnableFf <= regWdata[`MTW_BIT_OVF_IE]; // [RULE8]
        periodicIrqEnableFf <= regWdata[`MTW_BIT_PER_IE];
        rateSelFf <= regWdata[`MTW_BIT_RATE_HI:`MTW_BIT_RATE_LO]; // [RULE11]
      end
      if (lowWrap && stateFf == ST_RUN)
        overflowFlagFf <= 1'b1; // [RULE1]
      else if (wrStatus && regWdata[`MTW_BIT_OVF_FRST])
        overflowFlagFf <= 1'b0; // [RULE3]
      if (periodicTap)
        periodicFlagFf <= 1'b1; // [RULE4]
      else if (wrStatus && regWdata[`MTW_BIT_PER_FRST])
        periodicFlagFf <= 1'b0; // [RULE5]
    end
  end

  // Registered requests
  always @(posedge sys_clk) begin
    if (!rstn) begin
      overflowIrq <= 1'b0;
      periodicIrq <= 1'b0;
      watchdogResetReq <= 1'b0;
    end else begin
      overflowIrq <= overflowFlagFf && overflowIrqEnableFf; // [RULE2]
      periodicIrq <= periodicFlagFf && periodicIrqEnableFf; // [RULE4]
      // Disabled or stopped watchdog never asserts reset
      watchdogResetReq <= wdExpired && watchdogEnableOption && !stopMode; // [RULE21]
    end
  end

  // Read data one cycle after the strobe; reset bits read zero
  always @(posedge sys_clk) begin
    if (!rstn) begin
      regRdata <= `MTW_ZERO8;
    end else if (regRd) begin
      case (regAddr)
        `MTW_ADDR_STATUS: regRdata <= {overflowFlagFf, periodicFlagFf,
          overflowIrqEnableFf, periodicIrqEnableFf, 2'b00, rateSelFf}; // [RULE7]
        `MTW_ADDR_COUNT: regRdata <= chainFf[7:0]; // [RULE14]
        default: regRdata <= `MTW_ZERO8; // [RULE19]
      endcase
    end else begin
      regRdata <= `MTW_ZERO8;
    end
  end

  // Watchdog stages after the tap
  mtw_watchdog #(
    .WIDTH(`MTW_WDOG_W)
  ) uWatchdog (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .tick(periodicTap), // [RULE11]
    .clear(wdClear || stateFf == ST_POR), // [RULE18]
    .enable(watchdogEnableOption && !stopMode), // [RULE20]
    .expired(wdExpired)
  );
endmodule

// [test/mtw_timer_chk.sv]
// Checker of the timer register port and request outputs
`timescale 1ns/1ps
`include "mtw_timer_regs.vh"
module mtw_timer_chk #(
  parameter POR_LONG = 4064,
  parameter POR_SHORT = 16
) (
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Register port
  input wire [10:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWr,
  input wire regRd,
  input wire [7:0] regRdata,
  // Options
  input wire watchdogEnableOption,
  input wire shortStartupDelayOption,
  input wire stopMode,
  // Requests
  input wire overflowIrq,
  input wire periodicIrq,
  input wire watchdogResetReq,
  input wire porActive
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Status write with one chosen bit high or low
  sequence sStHi(b);
    regWr && regAddr == `MTW_ADDR_STATUS && regWdata[b];
  endsequence
  sequence sStLo(b);
    regWr && regAddr == `MTW_ADDR_STATUS && !regWdata[b];
  endsequence
  // Clear is a write of zero in bit 0
  sequence sWdClr;
    regWr && regAddr == `MTW_ADDR_WDOG_CLR && !regWdata[`MTW_BIT_WDOG_CLR];
  endsequence
  chk_rdata_idle: assert property (!$past(regRd) |-> regRdata == `MTW_ZERO8)
    else $error("read data not zero outside read cycle");
  chk_ovf_clear: assert property (sStHi(`MTW_BIT_OVF_FRST) |-> ##2 !overflowIrq)
    else $error("overflow request survived flag reset");
  chk_ovf_mask: assert property (sStLo(`MTW_BIT_OVF_IE) |-> ##2 !overflowIrq)
    else $error("overflow request while disabled");
  chk_per_clear: assert property (sStHi(`MTW_BIT_PER_FRST) |-> ##2 !periodicIrq)
    else $error("periodic request survived flag reset");
  chk_wdog_clr_safe: assert property (sWdClr |-> ##2 !watchdogResetReq [*8])
    else $error("watchdog reset right after clear");
  chk_wdog_pulse: assert property (watchdogResetReq |=> !watchdogResetReq)
    else $error("watchdog reset longer than one cycle");
  chk_wdog_opt_off: assert property (!watchdogEnableOption && !$past(watchdogEnableOption)
    |-> !watchdogResetReq)
    else $error("watchdog reset while option off");
  chk_stop_off: assert property (stopMode && $past(stopMode) |-> !watchdogResetReq)
    else $error("watchdog reset in stop mode");
  chk_por_short: assert property ($rose(rstn) && shortStartupDelayOption
    |-> porActive [*8] ##[1:12] !porActive)
    else $error("short power-on delay wrong");
endmodule

// [test/tb_mtw_timer.sv]
// Self-checking bench of the multifunction timer
`timescale 1ns/1ps
`include "mtw_timer_regs.vh"
module tb_mtw_timer;
  reg sys_clk = 0, rstn = 0, regWr = 0, regRd = 0, wdOpt = 0, shortOpt = 1, stopMode = 0;
  reg [10:0] regAddr = 0;
  reg [7:0] regWdata = 0, d;
  wire [7:0] regRdata;
  wire overflowIrq, periodicIrq, watchdogResetReq, porActive;
  integer error_cnt = 0, checks = 0, cyc = 0, n;
  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;
  mtw_timer #(.POR_LONG(40), .POR_SHORT(16)) i_dut (.sys_clk(sys_clk), .rstn(rstn),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .watchdogEnableOption(wdOpt), .shortStartupDelayOption(shortOpt),
    .stopMode(stopMode), .overflowIrq(overflowIrq), .periodicIrq(periodicIrq),
    .watchdogResetReq(watchdogResetReq), .porActive(porActive));
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard, about 33k cycles expected
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt = error_cnt + 1;
      tally_and_finish;
    end
  end
  task wr(input [10:0] a, input [7:0] v);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1;
    @(posedge sys_clk);
    regWr <= 0;
  endtask
  // Data sampled 1 ns after the answering edge, when settled
  task rd(input [10:0] a);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1;
    @(posedge sys_clk);
    regRd <= 0;
    #1 d = regRdata;
  endtask
  task cmp(input string nm, input [15:0] e, input [15:0] s);
    checks = checks + 1;
    if (s !== e) begin
      error_cnt = error_cnt + 1;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task waitIrq(input bit p, input integer lim);
    n = 0;
    while ((p ? periodicIrq : overflowIrq) !== 1'b1 && n < lim) begin
      @(posedge sys_clk);
      #1 n = n + 1;
    end
  endtask
  // Rise to rise spacing; the clearing write and the request fall cost four cycles
  task period(input bit p, input [7:0] clr, input [15:0] e);
    waitIrq(p, e + 100);
    cmp("irq", 1, p ? periodicIrq : overflowIrq);
    wr(`MTW_ADDR_STATUS, clr);
    repeat (2) @(posedge sys_clk);
    #1;
    waitIrq(p, e + 100);
    cmp("gap", e, n[15:0]);
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    rstn <= 1;
    rd(`MTW_ADDR_STATUS);
    cmp("status", 8'h03, d);
    rd(`MTW_ADDR_WDOG_CLR);
    cmp("wdclr", 8'h00, d);
    repeat (20) @(posedge sys_clk);
    rd(`MTW_ADDR_COUNT);
    n = d;
    repeat (38) @(posedge sys_clk);
    rd(`MTW_ADDR_COUNT);
    cmp("count", 8'h0A, d - n[7:0]);
    wr(`MTW_ADDR_WDOG_CLR, 8'h00);
    wr(`MTW_ADDR_STATUS, 8'hFC);
    rd(`MTW_ADDR_STATUS);
    cmp("status", 8'h30, d);
    $display("test registers done");
    period(0, 8'h38, 16'd1020);
    wr(`MTW_ADDR_STATUS, 8'h18);
    repeat (1100) @(posedge sys_clk);
    #1 cmp("ovfIrq", 0, overflowIrq);
    rd(`MTW_ADDR_STATUS);
    cmp("status", 8'h90, d & 8'hF0);
    $display("test overflow done");
    period(1, 8'h14, 16'd16380);
    wr(`MTW_ADDR_STATUS, 8'h14);
    @(posedge sys_clk);
    #1 cmp("perIrq", 0, periodicIrq);
    $display("test periodic done");
    wdOpt <= 1;
    wr(`MTW_ADDR_WDOG_CLR, 8'h00);
    stopMode <= 1;
    repeat (20) @(posedge sys_clk);
    #1 cmp("wdReset", 0, watchdogResetReq);
    $display("test watchdog done");
    tally_and_finish;
  end
endmodule
bind mtw_timer mtw_timer_chk #(.POR_LONG(POR_LONG), .POR_SHORT(POR_SHORT)) u_chk (
  .sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata), .watchdogEnableOption(watchdogEnableOption),
  .shortStartupDelayOption(shortStartupDelayOption), .stopMode(stopMode),
  .overflowIrq(overflowIrq), .periodicIrq(periodicIrq),
  .watchdogResetReq(watchdogResetReq), .porActive(porActive));
